// ==== src/amt_pkg.sv ====
package amt_pkg;

	// Register indices; byte address is four times the index
	localparam logic [7:0] IDX_BUF_OFF_LOW  = 8'h01;
	localparam logic [7:0] IDX_BUF_OFF_HIGH = 8'h02;
	localparam logic [7:0] IDX_CTRL_B       = 8'h03;
	localparam logic [7:0] IDX_RESULT_LOW   = 8'h04;
	localparam logic [7:0] IDX_RESULT_HIGH  = 8'h05;
	localparam logic [7:0] IDX_CTRL_A       = 8'h06;
	localparam logic [7:0] IDX_CHAN_ALIGN   = 8'h07;

	// Reset values
	localparam logic [7:0] RST_BYTE = 8'h00;
	localparam logic [9:0] RST_RES  = 10'h000;

	// Control register A fields
	localparam int CA_ENABLE = 7;
	localparam int CA_START  = 6;
	localparam int CA_AUTO   = 5;
	localparam int CA_DONE   = 4;

	// Control register B fields
	localparam int CB_BIPOLAR = 7;
	localparam int CB_GAIN_HI = 6;
	localparam int CB_RSVD    = 5;
	localparam int CB_REF_HI  = 4;
	localparam int CB_MUX_MSB = 3;

	// Channel/align register fields
	localparam int CM_ALIGN = 5;

	// Selector landmarks
	localparam logic [5:0] SEL_LAST_SINGLE = 6'h0A;
	localparam logic [5:0] SEL_BANDGAP     = 6'h1E;
	localparam logic [5:0] SEL_GROUND      = 6'h1F;
	localparam logic [5:0] SEL_OFS_LOW_G   = 6'h39;
	localparam logic [5:0] SEL_TEMP        = 6'h3F;
	localparam logic [2:0] TRIG_FREE_RUN   = 3'h0;

	// AHB-Lite
	localparam logic [1:0] HTRANS_NONSEQ = 2'h2;

	typedef enum logic [1:0] {
		AMT_GAIN_1X  = 2'b00,
		AMT_GAIN_8X  = 2'b01,
		AMT_GAIN_20X = 2'b10,
		AMT_GAIN_32X = 2'b11
	} amt_gain_e;

	// Settings handed to the analog front end
	typedef struct packed {
		logic [5:0] chan_sel;
		logic [2:0] ref_sel;
		amt_gain_e  gain;
		logic       diff;
		logic       temp_sense;
		logic       bipolar;
	} amt_fe_cfg_s;

	typedef struct packed {
		logic        wr_pend;
		logic [7:0]  wr_idx;
		logic [31:0] hrdata;
		logic        left_align;
		logic [4:0]  mux_low;
		logic [1:0]  ref_lo;
		logic        bipolar;
		logic        gain_hi;
		logic        ref_hi;
		logic        mux_msb;
		logic [2:0]  trig_sel;
		logic [7:0]  off_low;
		logic [3:0]  off_high;
		logic        enable;
		logic        auto_en;
		logic        done;
		logic        busy;
		logic [9:0]  result;
		logic [5:0]  mux_app;
		logic [2:0]  ref_app;
		logic        trig_prev;
		logic        start;
		amt_fe_cfg_s fe;
		logic [11:0] buf_off;
		logic [11:0] sync1;
		logic [11:0] sync2;
		logic [11:0] port;
	} amt_state_s;

endpackage : amt_pkg

// ==== src/amt_ctrl.sv ====
// Register access over AHB-Lite was left to the implementer.
`timescale 1ns/1ps

// Overview of operation
// - Left-align bit shifts result left, else right
// - Align change affects result reads immediately
// - Six-bit selector from msb plus five bits
// - Codes 0-0A single-ended; 1E bandgap, 1F ground
// - Other codes pick differential pair and gain
// - Same-pin pairs allowed for offset measurement
// - Code 3F selects temperature sensor channel
// - Selector changes during conversion wait for completion
// - Unipolar default; negative input saturates
// - Bipolar two's complement, unipolar ten bits
// - Gain-upper bit gives 32x and 8x
// - Control B bit 5 reads zero
// - Reference high bit picks 1.1V or 2.56V
// - Auto trigger on selected flag rising edge
// - Switching to a set source triggers
// - Switching to free-running never triggers
// - Trigger source code map fixed
// - Low buffer-off bits mask analog pins 6-0
// - Bit 3 masks reference pin input
// - High buffer-off bits mask pins 10-7
// - Three reference bits map reference choice
// - Done flag set when result updates
// - Auto trigger starts conversion on positive edge
module amt_ctrl (
	input  wire logic                 MCLK,
	input  wire logic                 RSTN,
	input  wire logic                 HSEL,
	input  wire logic [31:0]          HADDR,
	input  wire logic [1:0]           HTRANS,
	input  wire logic                 HWRITE,
	input  wire logic [2:0]           HSIZE,
	input  wire logic [31:0]          HWDATA,
	input  wire logic                 HREADY,
	output logic      [31:0]          HRDATA,
	output logic                      HREADYOUT,
	output logic                      HRESP,
	input  wire logic [6:0]           TRIG_FLAGS,
	input  wire logic                 CONV_DONE,
	input  wire logic [9:0]           CONV_RESULT,
	output logic                      CONV_START,
	output logic                      CONV_ENABLE,
	output amt_pkg::amt_fe_cfg_s      FE_CFG,
	input  wire logic [11:0]          PORT_IN,
	output logic      [11:0]          PORT_IN_MASKED,
	output logic      [11:0]          BUF_OFF
);

	amt_pkg::amt_state_s st_q;
	amt_pkg::amt_state_s st_d;

	logic       addr_ok;
	logic       addr_take;
	logic [7:0] addr_idx;
	logic [5:0] sel_code;
	logic       trig_lvl;
	logic       trig_edge;
	logic       done_evt;
	logic       sw_start;
	logic       wr_a;

	// Gain from selector code and gain-upper bit
	function automatic amt_pkg::amt_gain_e gain_of(input logic [5:0] c, input logic g);
		logic hi;
		hi = 1'b1;
		if (c[5])
			hi = (c[5:3] == 3'h7) ? (c != amt_pkg::SEL_OFS_LOW_G) : !c[0];
		else
		begin
			case (c)
				6'h0C, 6'h0F, 6'h10, 6'h13, 6'h15, 6'h18, 6'h1A, 6'h1D: hi = 1'b0;
				default: hi = 1'b1;
			endcase
		end
		if (!is_diff(c))
			return amt_pkg::AMT_GAIN_1X;
		if (hi)
			return g ? amt_pkg::AMT_GAIN_32X : amt_pkg::AMT_GAIN_20X;
		return g ? amt_pkg::AMT_GAIN_8X : amt_pkg::AMT_GAIN_1X;
	endfunction : gain_of

	// Single-ended codes are the low block, bandgap, ground and sensor
	function automatic logic is_diff(input logic [5:0] c);
		return !(c <= amt_pkg::SEL_LAST_SINGLE || c == amt_pkg::SEL_BANDGAP ||
			c == amt_pkg::SEL_GROUND || c == amt_pkg::SEL_TEMP);
	endfunction : is_diff

	// Address phase decode
	assign addr_ok   = (HADDR[31:10] == 22'h000000) && (HADDR[1:0] == 2'h0);
	assign addr_take = HSEL && HREADY && (HTRANS == amt_pkg::HTRANS_NONSEQ);
	assign addr_idx  = HADDR[9:2];
	assign wr_a      = st_q.wr_pend && (st_q.wr_idx == amt_pkg::IDX_CTRL_A);

	// Trigger level; code zero forces low so free-running adds no edge
	always_comb
	begin
		if (st_q.trig_sel == amt_pkg::TRIG_FREE_RUN)
			trig_lvl = 1'b0;
		else
			trig_lvl = TRIG_FLAGS[st_q.trig_sel - 3'h1];
	end
	assign trig_edge = trig_lvl && !st_q.trig_prev;
	assign done_evt  = CONV_DONE && st_q.busy;

	// Next-state logic
	always_comb
	begin
		st_d       = st_q;
		st_d.start = 1'b0;
		sw_start   = 1'b0;
		sel_code   = 6'h00;

		// Register reads sample state at the address edge
		if (addr_take && !HWRITE)
		begin
			st_d.hrdata = 32'h00000000;
			if (!addr_ok)
				st_d.hrdata = 32'h00000000;
			else if (addr_idx == amt_pkg::IDX_BUF_OFF_LOW)
				st_d.hrdata[7:0] = st_q.off_low;
			else if (addr_idx == amt_pkg::IDX_BUF_OFF_HIGH)
				st_d.hrdata[7:0] = {st_q.off_high, 4'h0};
			else if (addr_idx == amt_pkg::IDX_CTRL_B)
				st_d.hrdata[7:0] = {st_q.bipolar, st_q.gain_hi, 1'b0, st_q.ref_hi,
					st_q.mux_msb, st_q.trig_sel};
			else if (addr_idx == amt_pkg::IDX_RESULT_LOW)
				st_d.hrdata[7:0] = st_q.left_align ? {st_q.result[1:0], 6'h00}
					: st_q.result[7:0];
			else if (addr_idx == amt_pkg::IDX_RESULT_HIGH)
				st_d.hrdata[7:0] = st_q.left_align ? st_q.result[9:2]
					: {6'h00, st_q.result[9:8]};
			else if (addr_idx == amt_pkg::IDX_CTRL_A)
				st_d.hrdata[7:0] = {st_q.enable, st_q.busy, st_q.auto_en, st_q.done, 4'h0};
			else if (addr_idx == amt_pkg::IDX_CHAN_ALIGN)
				st_d.hrdata[7:0] = {st_q.ref_lo, st_q.left_align, st_q.mux_low};
		end

		// Writes land in the data phase
		st_d.wr_pend = addr_take && HWRITE && addr_ok;
		st_d.wr_idx  = addr_idx;

		// Conversion completion; set beats a same-cycle clear
		if (done_evt)
		begin
			st_d.result = CONV_RESULT;
			st_d.busy   = 1'b0;
		end

		if (st_q.wr_pend)
		begin
			if (st_q.wr_idx == amt_pkg::IDX_BUF_OFF_LOW)
				st_d.off_low = HWDATA[7:0];
			else if (st_q.wr_idx == amt_pkg::IDX_BUF_OFF_HIGH)
				st_d.off_high = HWDATA[7:4];
			else if (st_q.wr_idx == amt_pkg::IDX_CTRL_B)
			begin
				st_d.bipolar  = HWDATA[amt_pkg::CB_BIPOLAR];
				st_d.gain_hi  = HWDATA[amt_pkg::CB_GAIN_HI];
				st_d.ref_hi   = HWDATA[amt_pkg::CB_REF_HI];
				st_d.mux_msb  = HWDATA[amt_pkg::CB_MUX_MSB];
				st_d.trig_sel = HWDATA[2:0];
			end
			else if (st_q.wr_idx == amt_pkg::IDX_CTRL_A)
			begin
				st_d.enable  = HWDATA[amt_pkg::CA_ENABLE];
				st_d.auto_en = HWDATA[amt_pkg::CA_AUTO];
				if (HWDATA[amt_pkg::CA_DONE])
					st_d.done = 1'b0;
				sw_start = HWDATA[amt_pkg::CA_START];
				// Turning off aborts a running conversion
				if (!HWDATA[amt_pkg::CA_ENABLE])
					st_d.busy = 1'b0;
			end
			else if (st_q.wr_idx == amt_pkg::IDX_CHAN_ALIGN)
			begin
				st_d.ref_lo     = HWDATA[7:6];
				st_d.left_align = HWDATA[amt_pkg::CM_ALIGN];
				st_d.mux_low    = HWDATA[4:0];
			end
		end
		if (done_evt)
			st_d.done = 1'b1;

		// Selector and reference only move between conversions
		sel_code = {st_d.mux_msb, st_d.mux_low};
		if (!st_q.busy || done_evt)
		begin
			st_d.mux_app = sel_code;
			st_d.ref_app = {st_d.ref_hi, st_d.ref_lo};
		end

		// Start: software, trigger edge, or free-running restart
		st_d.trig_prev = trig_lvl;
		if (st_d.enable && !st_d.busy)
		begin
			if (sw_start ||
				(st_q.auto_en && trig_edge) ||
				(st_q.auto_en && done_evt && st_q.trig_sel == amt_pkg::TRIG_FREE_RUN))
			begin
				st_d.start = 1'b1;
				st_d.busy  = 1'b1;
			end
		end

		// Front-end settings
		st_d.fe.chan_sel   = st_d.mux_app;
		st_d.fe.ref_sel    = st_d.ref_app;
		st_d.fe.gain       = gain_of(st_d.mux_app, st_d.gain_hi);
		st_d.fe.diff       = is_diff(st_d.mux_app);
		st_d.fe.temp_sense = (st_d.mux_app == amt_pkg::SEL_TEMP);
		st_d.fe.bipolar    = st_d.bipolar;

		// Pin buffers; masking uses the same new disable vector
		st_d.buf_off = {st_d.off_low[3], st_d.off_high, st_d.off_low[7:4],
			st_d.off_low[2:0]};
		st_d.sync1   = PORT_IN;
		st_d.sync2   = st_q.sync1;
		st_d.port    = st_q.sync2 & ~st_d.buf_off;
	end

	// State register
	always_ff @(posedge MCLK or negedge RSTN)
	begin
		if (!RSTN)
			st_q <= '0;
		else
			st_q <= st_d;
	end

	// Outputs straight from flops; the slave never stalls
	always_ff @(posedge MCLK or negedge RSTN)
	begin
		if (!RSTN)
		begin
			HREADYOUT <= 1'b1;
			HRESP     <= 1'b0;
		end
		else
		begin
			HREADYOUT <= 1'b1;
			HRESP     <= 1'b0;
		end
	end

	assign HRDATA         = st_q.hrdata;
	assign CONV_START     = st_q.start;
	assign CONV_ENABLE    = st_q.enable;
	assign FE_CFG         = st_q.fe;
	assign PORT_IN_MASKED = st_q.port;
	assign BUF_OFF        = st_q.buf_off;

	default clocking cb @(posedge MCLK);
	endclocking
	default disable iff (!RSTN);

	a_start_needs_en: assert property (CONV_START |-> CONV_ENABLE && st_q.busy)
		else $error("start without enable");
	a_done_sets_flag: assert property (done_evt |=> st_q.done)
		else $error("done flag not set");
	a_result_capture: assert property (done_evt |=> st_q.result == $past(CONV_RESULT))
		else $error("result not captured");
	a_mux_held_busy: assert property ((st_q.busy && !CONV_DONE) |=>
		FE_CFG.chan_sel == $past(FE_CFG.chan_sel))
		else $error("selector moved mid conversion");
	a_reserved_zero: assert property ((addr_take && !HWRITE && addr_ok
		&& addr_idx == amt_pkg::IDX_CTRL_B) |=> HRDATA[amt_pkg::CB_RSVD] == 1'b0)
		else $error("reserved bit nonzero");
	a_align_read: assert property ((addr_take && !HWRITE && addr_ok
		&& addr_idx == amt_pkg::IDX_RESULT_HIGH && st_q.left_align)
		|=> HRDATA[7:0] == $past(st_q.result[9:2]))
		else $error("left aligned high byte wrong");
	a_port_mask: assert property ((PORT_IN_MASKED & BUF_OFF) == 12'h000)
		else $error("disabled pin reads one");
	a_free_run_quiet: assert property ((st_q.trig_sel == amt_pkg::TRIG_FREE_RUN
		&& !CONV_DONE && !wr_a) |=> !CONV_START)
		else $error("free-running switch triggered");
	a_trig_edge_start: assert property ((st_q.auto_en && st_q.enable && !st_q.busy
		&& trig_edge && !st_q.wr_pend && !CONV_DONE) |=> CONV_START ##1 !CONV_START)
		else $error("trigger edge missed");
	a_free_run_restart: assert property ((st_q.auto_en && st_q.enable && done_evt && !wr_a
		&& st_q.trig_sel == amt_pkg::TRIG_FREE_RUN) |=> CONV_START)
		else $error("free-running restart missed");

	// Done flag: only a written one clears it, so software never loses a result
	a_done_clear: assert property ((wr_a && HWDATA[amt_pkg::CA_DONE] && !done_evt)
		|=> !st_q.done)
		else $error("done flag not cleared");
	a_done_holds: assert property ((st_q.done && !wr_a)
		|=> st_q.done)
		else $error("done flag dropped");

	// Result bytes in both alignments; align acts even mid conversion
	a_right_low: assert property ((addr_take && !HWRITE && addr_ok
		&& addr_idx == amt_pkg::IDX_RESULT_LOW && !st_q.left_align)
		|=> HRDATA[7:0] == $past(st_q.result[7:0]))
		else $error("right aligned low byte wrong");
	a_right_high: assert property ((addr_take && !HWRITE && addr_ok
		&& addr_idx == amt_pkg::IDX_RESULT_HIGH && !st_q.left_align)
		|=> HRDATA[7:0] == {6'h00, $past(st_q.result[9:8])})
		else $error("right aligned high byte wrong");
	a_left_low: assert property ((addr_take && !HWRITE && addr_ok
		&& addr_idx == amt_pkg::IDX_RESULT_LOW && st_q.left_align)
		|=> HRDATA[7:0] == {$past(st_q.result[1:0]), 6'h00})
		else $error("left aligned low byte wrong");
	a_align_now: assert property ((st_q.busy && st_q.wr_pend
		&& st_q.wr_idx == amt_pkg::IDX_CHAN_ALIGN)
		|=> st_q.left_align == $past(HWDATA[amt_pkg::CM_ALIGN]))
		else $error("align change deferred");
	a_msb_readback: assert property ((addr_take && !HWRITE && addr_ok
		&& addr_idx == amt_pkg::IDX_CTRL_B) |=> HRDATA[amt_pkg::CB_MUX_MSB] == $past(st_q.mux_msb))
		else $error("selector msb read back wrong");

	// Applied selector and reference follow the registers only between conversions
	a_sel_idle: assert property (!st_q.busy
		|=> st_q.mux_app == {st_q.mux_msb, st_q.mux_low})
		else $error("idle selector not applied");
	a_sel_on_done: assert property (done_evt
		|=> st_q.mux_app == {st_q.mux_msb, st_q.mux_low})
		else $error("deferred selector not applied");
	a_ref_held_busy: assert property ((st_q.busy && !CONV_DONE)
		|=> st_q.ref_app == $past(st_q.ref_app))
		else $error("reference moved mid conversion");
	a_ref_on_done: assert property (done_evt
		|=> st_q.ref_app == {st_q.ref_hi, st_q.ref_lo})
		else $error("deferred reference not applied");

	// Front-end settings match the applied selector in the same cycle
	a_fe_sel: assert property (FE_CFG.chan_sel == st_q.mux_app)
		else $error("front end selector stale");
	a_fe_ref: assert property (FE_CFG.ref_sel == st_q.ref_app)
		else $error("front end reference stale");
	a_temp_code: assert property (FE_CFG.temp_sense == (FE_CFG.chan_sel == amt_pkg::SEL_TEMP))
		else $error("sensor flag mismatch");
	a_single_gain: assert property (!FE_CFG.diff |-> FE_CFG.gain == amt_pkg::AMT_GAIN_1X)
		else $error("single-ended gain not 1x");
	a_gain_upper: assert property ((FE_CFG.diff && st_q.gain_hi)
		|-> FE_CFG.gain inside {amt_pkg::AMT_GAIN_8X, amt_pkg::AMT_GAIN_32X})
		else $error("upper gain not applied");
	a_gain_lower: assert property ((FE_CFG.diff && !st_q.gain_hi)
		|-> FE_CFG.gain inside {amt_pkg::AMT_GAIN_1X, amt_pkg::AMT_GAIN_20X})
		else $error("lower gain not applied");
	a_diff_codes: assert property ((FE_CFG.chan_sel > amt_pkg::SEL_LAST_SINGLE
		&& FE_CFG.chan_sel < amt_pkg::SEL_BANDGAP) |-> FE_CFG.diff)
		else $error("differential code not differential");
	a_bipolar_cfg: assert property (FE_CFG.bipolar == st_q.bipolar)
		else $error("bipolar mode not passed");

	// Start is one pulse and never overlaps a running conversion
	a_start_pulse: assert property ((CONV_START && !CONV_DONE) |=> !CONV_START)
		else $error("start longer than one cycle");
	a_no_start_busy: assert property ((st_q.busy && !CONV_DONE && !wr_a) |=> !CONV_START)
		else $error("start while busy");
	a_auto_off_quiet: assert property ((!st_q.auto_en && !wr_a) |=> !CONV_START)
		else $error("trigger acted with auto off");

	// Buffer disable bits land on their own pins
	a_buf_low_map: assert property ({BUF_OFF[6:3], BUF_OFF[2:0]}
		== {st_q.off_low[7:4], st_q.off_low[2:0]})
		else $error("low buffer map wrong");
	a_buf_ref_map: assert property (BUF_OFF[11] == st_q.off_low[3])
		else $error("reference pin buffer map wrong");
	a_buf_high_map: assert property (BUF_OFF[10:7] == st_q.off_high)
		else $error("high buffer map wrong");

	c_sw_conv: cover property (CONV_START ##[1:50] done_evt);
	c_trig_conv: cover property (st_q.auto_en && trig_edge ##1 CONV_START);
	c_deferred_sel: cover property (st_q.busy && st_q.wr_pend
		&& st_q.wr_idx == amt_pkg::IDX_CHAN_ALIGN ##[1:50] done_evt);
	c_done_clear_race: cover property (done_evt && wr_a && HWDATA[amt_pkg::CA_DONE]);
	c_free_run: cover property (st_q.auto_en && st_q.trig_sel == amt_pkg::TRIG_FREE_RUN
		&& done_evt ##1 CONV_START);

endmodule : amt_ctrl

// ==== verification/amt_core_model.sv ====
`timescale 1ns/1ps

// Converter core stand-in: answers each start after a set delay
module amt_core_model (
	input  wire logic       clk,
	input  wire logic       rst_n,
	input  wire logic       start,
	input  wire logic [7:0] delay,
	input  wire logic [9:0] value,
	output logic            done,
	output logic [9:0]      result
);
	logic [7:0] cnt_q;

	// Result toggles outside the done pulse so stale data never passes
	always_ff @(posedge clk or negedge rst_n)
	begin
		if (!rst_n)
		begin
			cnt_q  <= 8'h00;
			done   <= 1'b0;
			result <= 10'h000;
		end
		else
		begin
			done   <= 1'b0;
			result <= ~result;
			if (start)
				cnt_q <= delay;
			else if (cnt_q != 8'h00)
			begin
				cnt_q <= cnt_q - 8'h01;
				if (cnt_q == 8'h01)
				begin
					done   <= 1'b1;
					result <= value;
				end
			end
		end
	end
endmodule : amt_core_model

// ==== verification/tb.sv ====
`timescale 1ns/1ps

module tb;
	localparam logic [7:0] CB = amt_pkg::IDX_CTRL_B;
	localparam logic [7:0] CA = amt_pkg::IDX_CTRL_A;
	localparam logic [7:0] CM = amt_pkg::IDX_CHAN_ALIGN;
	logic                 MCLK, RSTN, HWRITE, HRESP, CONV_DONE, CONV_START, CONV_ENABLE, HREADYOUT, rd_dp;
	logic [31:0]          HADDR, HWDATA, HRDATA, exp_q[$];
	logic [1:0]           HTRANS;
	logic [6:0]           TRIG_FLAGS;
	logic [9:0]           CONV_RESULT, val;
	logic [11:0]          PORT_IN, PORT_IN_MASKED, BUF_OFF;
	logic [7:0]           dly;
	logic [5:0]           codes[6] = '{6'h0A, 6'h0B, 6'h1E, 6'h1F, 6'h39, 6'h3F};
	amt_pkg::amt_fe_cfg_s FE_CFG;
	int                   n_errors, n_tests, n_starts, cyc, seed, b;

	amt_ctrl dut (.MCLK(MCLK), .RSTN(RSTN), .HSEL(1'b1), .HADDR(HADDR), .HTRANS(HTRANS), .HWRITE(HWRITE),
		.HSIZE(3'h2), .HWDATA(HWDATA), .HREADY(HREADYOUT), .HRDATA(HRDATA), .HREADYOUT(HREADYOUT),
		.HRESP(HRESP), .TRIG_FLAGS(TRIG_FLAGS), .CONV_DONE(CONV_DONE), .CONV_RESULT(CONV_RESULT),
		.CONV_START(CONV_START), .CONV_ENABLE(CONV_ENABLE), .FE_CFG(FE_CFG), .PORT_IN(PORT_IN),
		.PORT_IN_MASKED(PORT_IN_MASKED), .BUF_OFF(BUF_OFF));
	amt_core_model core (.clk(MCLK), .rst_n(RSTN), .start(CONV_START), .delay(dly), .value(val),
		.done(CONV_DONE), .result(CONV_RESULT));

	task automatic tally_and_finish;
		if (n_errors == 0 && n_tests > 0)
			$display("NO MISMATCHES");
		else
			$display("MISMATCHES SEEN");
		$finish;
	endtask : tally_and_finish

	task automatic chk(input string nm, input logic [31:0] e, input logic [31:0] g);
		n_tests++;
		if (g !== e)
		begin
			n_errors++;
			$display("Error %s expected %h seen %h", nm, e, g);
		end
	endtask : chk

	// Address phase held until ready, then data phase held until ready
	task automatic bus(input logic [7:0] idx, input logic wr, input logic [7:0] wd, input logic [7:0] e);
		@(posedge MCLK);
		HTRANS <= amt_pkg::HTRANS_NONSEQ;
		HADDR  <= {22'h0, idx, 2'b00};
		HWRITE <= wr;
		@(posedge MCLK);
		while (HREADYOUT !== 1'b1)
			@(posedge MCLK);
		HTRANS <= 2'h0;
		HWDATA <= {24'h0, wd};
		rd_dp  <= !wr;
		if (!wr)
			exp_q.push_back({24'h0, e});
		@(posedge MCLK);
		while (HREADYOUT !== 1'b1)
			@(posedge MCLK);
		rd_dp <= 1'b0;
	endtask : bus

	task automatic wait_done;
		for (int i = 0; i < 100 && CONV_DONE !== 1'b1; i++)
			@(posedge MCLK);
		repeat (3) @(posedge MCLK);
	endtask : wait_done

	// Start count before and after a few idle cycles
	task automatic starts(input int e);
		repeat (5) @(posedge MCLK);
		chk("starts", e, n_starts - b);
		b = n_starts;
	endtask : starts

	initial
	begin
		MCLK = 1'b0;
		forever #5 MCLK = ~MCLK;
	end

	// Read data taken at the edge ending the data phase
	always @(posedge MCLK)
	begin
		cyc++;
		if (CONV_START === 1'b1)
			n_starts++;
		if (rd_dp === 1'b1 && HREADYOUT === 1'b1 && exp_q.size() > 0)
		begin
			chk("hresp", 32'h0, {31'h0, HRESP});
			chk("hrdata", exp_q.pop_front(), HRDATA);
		end
		if (cyc > 20000)
		begin
			n_errors++;
			tally_and_finish();
		end
	end

	initial
	begin
		seed = 32'hbb9c;
		{RSTN, HWRITE, rd_dp, HTRANS, HADDR, HWDATA, TRIG_FLAGS, PORT_IN} = '0;
		dly = 8'd20;
		val = 10'($random(seed));
		repeat (4) @(posedge MCLK);
		RSTN <= 1'b1;
		bus(CB, 0, 0, 8'h00);
		bus(8'h00, 0, 0, 8'h00);
		bus(CM, 1, 8'hC0, 0);
		bus(CB, 1, 8'hFF, 0);
		bus(CB, 0, 0, 8'hDF);
		chk("ref", 3'h7, FE_CFG.ref_sel);
		chk("gain", amt_pkg::AMT_GAIN_32X, FE_CFG.gain);
		chk("sel", 6'h20, FE_CFG.chan_sel);
		chk("bipolar", 1'b1, FE_CFG.bipolar);
		// Single-ended, differential, reference, ground, offset and sensor codes
		foreach (codes[i])
		begin
			bus(CB, 1, {4'h0, codes[i][5], 3'h0}, 0);
			bus(CM, 1, {3'h0, codes[i][4:0]}, 0);
			repeat (2) @(posedge MCLK);
			chk("sel", codes[i], FE_CFG.chan_sel);
			chk("diff", codes[i] inside {6'h0B, 6'h39}, FE_CFG.diff);
			chk("temp", codes[i] == 6'h3F, FE_CFG.temp_sense);
		end
		bus(CM, 1, 8'h01, 0);
		bus(CA, 1, 8'h80, 0);
		bus(CA, 1, 8'hC0, 0);
		bus(CM, 1, 8'h05, 0);
		repeat (2) @(posedge MCLK);
		chk("held", 6'h21, FE_CFG.chan_sel);
		chk("enable", 1'b1, CONV_ENABLE);
		wait_done();
		chk("applied", 6'h25, FE_CFG.chan_sel);
		bus(CA, 0, 0, 8'h90);
		bus(8'h04, 0, 0, val[7:0]);
		bus(8'h05, 0, 0, {6'h0, val[9:8]});
		bus(CM, 1, 8'h25, 0);
		bus(8'h05, 0, 0, val[9:2]);
		bus(8'h04, 0, 0, {val[1:0], 6'h0});
		dly = 8'd3;
		bus(CA, 1, 8'hB0, 0);
		bus(CA, 0, 0, 8'hA0);
		// Each source triggers only on its own flag edge
		for (int s = 1; s < 8; s++)
		begin
			bus(CB, 1, 8'(s), 0);
			b = n_starts;
			TRIG_FLAGS <= ~(7'h01 << (s - 1));
			starts(0);
			TRIG_FLAGS <= 7'h7F;
			starts(1);
			TRIG_FLAGS <= 7'h00;
			wait_done();
		end
		TRIG_FLAGS <= 7'h01;
		bus(CB, 1, 8'h02, 0);
		starts(0);
		bus(CB, 1, 8'h01, 0);
		starts(1);
		wait_done();
		bus(CB, 1, 8'h00, 0);
		starts(0);
		// Free-running: one software start, then a restart on each completion
		bus(CA, 1, 8'hE0, 0);
		starts(1);
		starts(1);
		// Auto off: switching onto a set flag must not start
		bus(CA, 1, 8'h80, 0);
		TRIG_FLAGS <= 7'h7F;
		bus(CB, 1, 8'h07, 0);
		b = n_starts;
		starts(0);
		PORT_IN <= 12'($random(seed));
		bus(8'h01, 1, 8'hFF, 0);
		bus(8'h02, 1, 8'hF0, 0);
		repeat (4) @(posedge MCLK);
		chk("off", 12'hFFF, BUF_OFF);
		chk("pins", 12'h000, PORT_IN_MASKED);
		PORT_IN <= 12'hFFF;
		bus(8'h01, 1, 8'h08, 0);
		bus(8'h02, 1, 8'h00, 0);
		bus(8'h01, 0, 0, 8'h08);
		repeat (4) @(posedge MCLK);
		chk("pins", 12'h7FF, PORT_IN_MASKED);
		chk("off", 12'h800, BUF_OFF);
		tally_and_finish();
	end
endmodule : tb
